// >>> scs_cfg.svh
// Offsets, field positions, reset values and counts of the clock switch block
//
// Summary of operation
// [RULE_01] Setting mid_osc_enable, run control bit 1, starts the middle-speed oscillator.
// [RULE_02] Software waits at least 4us for the middle-speed oscillator before selecting it.
// [RULE_03] Clearing subsystem_select, select bit 6, routes the main system clock out.
// [RULE_04] Bit 7 reports the active source; software stops the sub oscillator after zero.
// [RULE_05] Software leaves main_source_select unchanged while running from the sub clock.
// [RULE_06] For the middle-speed target software writes select bits 1 and 0 set.
// [RULE_07] Settle select bits 2..0 choose crystal settle time; 010 gives 102us at 10MHz.
// [RULE_08] With an external clock software may skip programming settle select.
// [RULE_09] Clearing hs_osc_stop, run control bit 7, starts the high-speed oscillator.
// [RULE_10] Settle status fills from bit 7 downward; bits 7..5 set mean 102us elapsed.
// [RULE_11] With an external clock software omits the settle wait before switching.
// [RULE_12] For high-speed target software sets bit 4 and clears bit 6 after settling.
// [RULE_13] Order: start oscillator, wait, select, confirm status, stop the sub oscillator.
// [RULE_14] Software writes reserved bits as zero in the three writable registers.
// [RULE_15] With main_source_select clear the main clock comes from the internal oscillator.
// [RULE_16] Select bit 7 reads one while the CPU clock runs from the subsystem clock.
// [RULE_17] Select bit 5 shows the active main source; zero for the internal oscillator.
// [RULE_18] Status bits change only after the glitch-free multiplexer switch completes.
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
`define SCS_ADDR_RUN_CTL 2'h0
`define SCS_ADDR_CLK_SEL 2'h1
`define SCS_ADDR_SETTLE_SEL 2'h2
`define SCS_ADDR_SETTLE_STAT 2'h3
`define SCS_RUN_HS_STOP 7
`define SCS_RUN_SUB_STOP 6
`define SCS_RUN_MID_EN 1
`define SCS_RUN_FAST_STOP 0
`define SCS_RUN_WMASK 8'hc3
`define SCS_RUN_RESET 8'h80
`define SCS_SEL_SUB_STAT 7
`define SCS_SEL_SUB 6
`define SCS_SEL_MAIN_STAT 5
`define SCS_SEL_MAIN 4
`define SCS_SEL_INT_STAT 1
`define SCS_SEL_INT 0
`define SCS_SETTLE_RESET 3'h7
`define SCS_MUX_GAP 2'h2
`endif

// >>> scs_pkg.sv
// Types shared by the clock switch block
`default_nettype none
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_SRC_FAST = 2'b00,
    SCS_SRC_MID = 2'b01,
    SCS_SRC_HS = 2'b10,
    SCS_SRC_SUB = 2'b11
  } scs_src_t;
  typedef enum logic [1:0] {
    SCS_MX_IDLE = 2'b00,
    SCS_MX_DRAIN = 2'b01,
    SCS_MX_SWAP = 2'b10
  } scs_mx_state_t;
  typedef struct packed {
    scs_mx_state_t state;
    logic [1:0] cnt;
    scs_src_t target;
    scs_src_t sel;
    scs_src_t active;
    logic gate;
  } scs_mux_st_t;
  typedef struct packed {
    logic [18:0] cnt;
  } scs_cnt_st_t;
  typedef struct packed {
    logic [7:0] run_ctl;
    logic sub_sel;
    logic main_sel;
    logic int_sel;
    logic [2:0] settle_sel;
    logic [7:0] rdata;
  } scs_top_st_t;
  // Settle select code to power-of-two count exponent
  function automatic logic [4:0] scs_exp(input logic [2:0] code);
    case (code)
      3'h0: scs_exp = 5'h08;
      3'h1: scs_exp = 5'h09;
      3'h2: scs_exp = 5'h0a;
      3'h3: scs_exp = 5'h0b;
      3'h4: scs_exp = 5'h0d;
      3'h5: scs_exp = 5'h0f;
      3'h6: scs_exp = 5'h11;
      default: scs_exp = 5'h12;
    endcase
  endfunction
  // Register bits to requested source
  function automatic scs_src_t scs_pick(input logic sub, input logic main, input logic intl);
    if (sub) begin
      scs_pick = SCS_SRC_SUB;
    end else if (main) begin
      scs_pick = SCS_SRC_HS;
    end else if (intl) begin
      scs_pick = SCS_SRC_MID;
    end else begin
      scs_pick = SCS_SRC_FAST;
    end
  endfunction
endpackage
`default_nettype wire

// >>> scs_settle_cnt.sv
// Oscillation settle counter for the high-speed crystal
`timescale 1ns/1ps
`default_nettype none
`include "scs_cfg.svh"
module scs_settle_cnt (
  input wire logic i_clk, // Block clock
  input wire logic i_rst, // Sync reset, high
  input wire logic i_run, // Oscillator enabled
  input wire logic i_osc_tick, // One pulse per oscillator cycle
  input wire logic [2:0] i_sel, // Settle time code
  output logic [7:0] o_status, // Settle status flags
  output logic o_stable // Selected time reached
);
  import scs_pkg::*;
  scs_cnt_st_t st;
  scs_cnt_st_t next_st;
  logic [18:0] limit;
  assign limit = 19'h00001 << scs_exp(i_sel);
  assign o_stable = (st.cnt >= limit);
  // [RULE_10] status from bit 7 down
  always_comb begin
    for (int j = 0; j < 8; j++) begin
      o_status[j] = (st.cnt >= (19'h00001 << scs_exp(3'(7 - j))));
    end
  end
  // [RULE_07] count stops at selected limit
  always_comb begin
    next_st = st;
    if (!i_run) begin
      next_st.cnt = 19'h00000;
    end else if (i_osc_tick && !o_stable) begin
      next_st.cnt = st.cnt + 19'h00001;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_CNT_CLEAR: assert property (!i_run |=> o_status == 8'h00) // [RULE_09]
    else $error("settle status not cleared while oscillator stopped");
  AST_STAT_ORDER: assert property (o_status[5] |-> o_status[7:6] == 2'b11) // [RULE_10]
    else $error("settle status not filled from the top");
endmodule // scs_settle_cnt
`default_nettype wire

// >>> scs_clk_mux.sv
// Glitch-free source switch sequencer for the CPU clock
`timescale 1ns/1ps
`default_nettype none
`include "scs_cfg.svh"
module scs_clk_mux (
  input wire logic i_clk, // Block clock
  input wire logic i_rst, // Sync reset, high
  input wire scs_pkg::scs_src_t i_req, // Requested source
  output scs_pkg::scs_src_t o_sel, // Mux select to clock tree
  output scs_pkg::scs_src_t o_active, // Confirmed source
  output logic o_gate, // Clock gate enable
  output logic o_busy // Switch in progress
);
  import scs_pkg::*;
  scs_mux_st_t st;
  scs_mux_st_t next_st;
  // Gate off, swap select, gate on; avoids runt pulses
  always_comb begin
    next_st = st;
    case (st.state)
      SCS_MX_IDLE: begin
        if (i_req != st.active) begin
          next_st.target = i_req;
          next_st.gate = 1'b0;
          next_st.cnt = `SCS_MUX_GAP;
          next_st.state = SCS_MX_DRAIN;
        end
      end
      SCS_MX_DRAIN: begin
        if (st.cnt == 2'h0) begin
          next_st.sel = st.target;
          next_st.cnt = `SCS_MUX_GAP;
          next_st.state = SCS_MX_SWAP;
        end else begin
          next_st.cnt = st.cnt - 2'h1;
        end
      end
      SCS_MX_SWAP: begin
        if (st.cnt == 2'h0) begin
          // [RULE_18] status changes in the same cycle as the gate reopens
          next_st.active = st.sel;
          next_st.gate = 1'b1;
          next_st.state = SCS_MX_IDLE;
        end else begin
          next_st.cnt = st.cnt - 2'h1;
        end
      end
      default: begin
        next_st.state = SCS_MX_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= {SCS_MX_IDLE, 2'h0, SCS_SRC_FAST, SCS_SRC_FAST, SCS_SRC_FAST, 1'b1};
    end else begin
      st <= next_st;
    end
  end
  assign o_sel = st.sel;
  assign o_active = st.active;
  assign o_gate = st.gate;
  assign o_busy = (st.state != SCS_MX_IDLE);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_SEL_GATED: assert property ($changed(o_sel) |-> !o_gate ##1 !o_gate) // [RULE_18]
    else $error("mux select changed with clock gate open");
  AST_ACT_AFTER: assert property ($changed(o_active) |-> o_gate && o_active == o_sel) // [RULE_18]
    else $error("active source reported before switch completed");
endmodule // scs_clk_mux
`default_nettype wire

// >>> scs_top.sv
// Clock switch registers, oscillator enables and source control
`timescale 1ns/1ps
`default_nettype none
`include "scs_cfg.svh"
module scs_top (
  input wire logic i_clk, // Block clock, 250 MHz
  input wire logic i_rst, // Sync reset, high
  input wire logic [1:0] i_addr, // Register address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [7:0] o_rdata, // Read data, one cycle later
  input wire logic i_hs_osc_tick, // High-speed oscillator cycle pulse
  output logic o_hs_osc_en, // High-speed oscillator run
  output logic o_sub_osc_en, // Sub oscillator run
  output logic o_mid_osc_en, // Middle-speed oscillator run
  output logic o_fast_osc_en, // Fast internal oscillator run
  output scs_pkg::scs_src_t o_clk_sel, // CPU clock mux select
  output logic o_clk_gate // CPU clock gate enable
);
  import scs_pkg::*;
  scs_top_st_t st;
  scs_top_st_t next_st;
  scs_src_t req_src;
  scs_src_t act_src;
  logic [7:0] settle_stat;
  logic settle_done;
  logic mux_busy;
  logic [7:0] sel_rd;
  logic sub_active;
  logic hs_active;
  logic mid_active;

  // Settle counter runs only while the crystal is enabled
  scs_settle_cnt u_settle (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(o_hs_osc_en),
    .i_osc_tick(i_hs_osc_tick),
    .i_sel(st.settle_sel),
    .o_status(settle_stat),
    .o_stable(settle_done)
  );

  // [RULE_03] select bit 6 picks sub or main
  // [RULE_15] main bit clear picks internal
  assign req_src = scs_pick(st.sub_sel, st.main_sel, st.int_sel);

  // Switch sequencer drives the real clock tree
  scs_clk_mux u_mux (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req(req_src),
    .o_sel(o_clk_sel),
    .o_active(act_src),
    .o_gate(o_clk_gate),
    .o_busy(mux_busy)
  );

  // Status reflects confirmed source, not request
  assign sub_active = (act_src == SCS_SRC_SUB);
  assign hs_active = (act_src == SCS_SRC_HS);
  assign mid_active = (act_src == SCS_SRC_MID);

  // [RULE_16] bit 7 tracks subsystem source
  // [RULE_17] bit 5 tracks main source
  always_comb begin
    sel_rd = 8'h00;
    sel_rd[`SCS_SEL_SUB_STAT] = sub_active;
    sel_rd[`SCS_SEL_SUB] = st.sub_sel;
    sel_rd[`SCS_SEL_MAIN_STAT] = hs_active;
    sel_rd[`SCS_SEL_MAIN] = st.main_sel;
    sel_rd[`SCS_SEL_INT_STAT] = mid_active;
    sel_rd[`SCS_SEL_INT] = st.int_sel;
  end

  // Register writes and registered read data
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    if (i_wr) begin
      case (i_addr)
        `SCS_ADDR_RUN_CTL: begin
          // [RULE_01] bit 1 starts middle-speed osc
          // [RULE_09] bit 7 clear starts crystal
          next_st.run_ctl = i_wdata & `SCS_RUN_WMASK;
        end
        `SCS_ADDR_CLK_SEL: begin
          // [RULE_04] status bits are read-only
          next_st.sub_sel = i_wdata[`SCS_SEL_SUB];
          next_st.main_sel = i_wdata[`SCS_SEL_MAIN];
          next_st.int_sel = i_wdata[`SCS_SEL_INT];
        end
        `SCS_ADDR_SETTLE_SEL: begin
          // [RULE_07] three-bit settle code
          next_st.settle_sel = i_wdata[2:0];
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `SCS_ADDR_RUN_CTL: begin
          next_st.rdata = st.run_ctl;
        end
        `SCS_ADDR_CLK_SEL: begin
          next_st.rdata = sel_rd;
        end
        `SCS_ADDR_SETTLE_SEL: begin
          next_st.rdata = {5'h00, st.settle_sel};
        end
        `SCS_ADDR_SETTLE_STAT: begin
          // [RULE_10] live settle flags
          next_st.rdata = settle_stat;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  // Single state register, reset to fast internal source
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st.run_ctl <= `SCS_RUN_RESET;
      st.sub_sel <= 1'b0;
      st.main_sel <= 1'b0;
      st.int_sel <= 1'b0;
      st.settle_sel <= `SCS_SETTLE_RESET;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // Oscillator enables straight from run control
  assign o_hs_osc_en = !st.run_ctl[`SCS_RUN_HS_STOP];
  assign o_sub_osc_en = !st.run_ctl[`SCS_RUN_SUB_STOP];
  assign o_mid_osc_en = st.run_ctl[`SCS_RUN_MID_EN];
  assign o_fast_osc_en = !st.run_ctl[`SCS_RUN_FAST_STOP];
  assign o_rdata = st.rdata;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Bus write and read sequences used by several checks
  sequence s_wr_run(logic b, int pos);
    i_wr && i_addr == `SCS_ADDR_RUN_CTL && i_wdata[pos] == b;
  endsequence
  sequence s_wr_sel;
    i_wr && i_addr == `SCS_ADDR_CLK_SEL;
  endsequence
  sequence s_rd_sel;
    i_rd && !i_wr && i_addr == `SCS_ADDR_CLK_SEL;
  endsequence

  AST_MID_START: assert property (s_wr_run(1'b1, 1) |=> o_mid_osc_en) // [RULE_01]
    else $error("middle-speed oscillator not started");
  AST_HS_START: assert property (s_wr_run(1'b0, 7) |=> o_hs_osc_en) // [RULE_09]
    else $error("high-speed oscillator not started");
  // Gate is still open the cycle after the write; allow a switch already under way
  AST_MAIN_SEL: assert property ( // [RULE_03]
    s_wr_sel ##0 !i_wdata[6] |-> ##[1:16] act_src != SCS_SRC_SUB)
    else $error("main system clock not routed after select clear");
  AST_INT_SRC: assert property (
    s_wr_sel ##0 i_wdata[6:4] == 3'b000 |-> ##[1:10] (act_src == SCS_SRC_FAST
      || act_src == SCS_SRC_MID) && !mux_busy) // [RULE_15]
    else $error("internal oscillator not used with main bit clear");
  AST_CLS_READ: assert property (s_rd_sel |=> o_rdata[7] == $past(sub_active)) // [RULE_16]
    else $error("subsystem status bit wrong");
  AST_MCS_READ: assert property (s_rd_sel |=> o_rdata[5] == $past(hs_active)) // [RULE_17]
    else $error("main source status bit wrong");
  AST_STAT_RO: assert property (
    s_wr_sel ##0 !mux_busy ##0 req_src == act_src |=> sub_active == $past(sub_active)) // [RULE_04]
    else $error("status bit changed by a write");
  AST_STAT_HOLD: assert property (mux_busy |=> $stable(act_src) || !mux_busy) // [RULE_18]
    else $error("status moved during a switch");
  AST_SETTLE_RD: assert property (
    i_rd && !i_wr && i_addr == `SCS_ADDR_SETTLE_STAT |=> o_rdata == $past(settle_stat)) // [RULE_10]
    else $error("settle status read wrong");
  AST_SETTLE_SEL: assert property (
    i_wr && i_addr == `SCS_ADDR_SETTLE_SEL |=> st.settle_sel == $past(i_wdata[2:0])) // [RULE_07]
    else $error("settle select not stored");
endmodule // scs_top
`default_nettype wire

// >>> scs_hs_osc_model.sv
// Behavioural high-speed crystal oscillator that feeds the settle counter
`timescale 1ns/1ps
`default_nettype none
module scs_hs_osc_model (
  input wire logic i_clk, // Block clock
  input wire logic i_en, // Oscillator run request
  output var logic o_tick, // One pulse per oscillator cycle
  output var int o_ticks // Ticks since the last start
);
  logic ph;
  initial begin
    ph = 1'b0;
    o_tick = 1'b0;
    o_ticks = 0;
  end
  // ticks only when enabled, as a clock already applied
  // Half rate stands in for a crystal slower than the block clock
  always @(posedge i_clk) begin
    ph <= i_en ? ~ph : 1'b0;
    o_tick <= i_en & ph;
    if (!i_en) begin
      o_ticks <= 0;
    end else if (o_tick) begin
      o_ticks <= o_ticks + 1;
    end
  end
endmodule // scs_hs_osc_model
`default_nettype wire

// >>> test_subclock_to_main_clock_switch.sv
// Self-checking bench for the sub clock to main clock switch
`timescale 1ns/1ps
`default_nettype none
`include "scs_cfg.svh"
module test_subclock_to_main_clock_switch;
  import scs_pkg::*;
  logic i_clk, i_rst, i_wr, i_rd, hs_tick, hs_en, sub_en, mid_en, fast_en, gate;
  logic [1:0] i_addr;
  logic [7:0] i_wdata, o_rdata, rv;
  scs_src_t clk_sel;
  int ticks, failures, check_count;
  scs_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_hs_osc_tick(hs_tick),
    .o_hs_osc_en(hs_en), .o_sub_osc_en(sub_en), .o_mid_osc_en(mid_en),
    .o_fast_osc_en(fast_en), .o_clk_sel(clk_sel), .o_clk_gate(gate));
  scs_hs_osc_model i_osc (.i_clk(i_clk), .i_en(hs_en), .o_tick(hs_tick), .o_ticks(ticks));
  // Free-running 250 MHz clock
  always #2 i_clk = ~i_clk;
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic chk_min(input int got, input int lo, input string what);
    check_count++;
    if (got < lo) begin
      failures++;
      $display("Error at %0t: %s %0d below %0d", $time, what, got, lo);
    end
  endtask
  // Bus write: returns just after the edge that takes it, so outputs have settled
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rv = o_rdata;
  endtask
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp, input string what);
    rd(a);
    chk_byte(rv, exp, what);
  endtask
  // Select write, then gate drop, mux change and gate return timed
  task automatic do_switch(input logic [7:0] d, input scs_src_t src, input logic [7:0] m,
    input logic [7:0] exp);
    int n;
    wr(`SCS_ADDR_CLK_SEL, d);
    n = 0;
    while (gate !== 1'b0 && n < 6) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk_bit(gate, 1'b0, "gate drop");
    n = 0;
    while (clk_sel !== src && n < 10) begin
      chk_bit(gate, 1'b0, "gate low while swapping");
      @(posedge i_clk);
      #1;
      n++;
    end
    chk_byte(8'(n), 8'h03, "gate drop to select");
    n = 0;
    while (gate !== 1'b1 && n < 10) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk_byte(8'(n), 8'h03, "select to gate rise");
    chk_byte({6'h00, clk_sel}, {6'h00, src}, "mux select");
    rd(`SCS_ADDR_CLK_SEL);
    chk_byte(rv & m, exp, "select status");
  endtask
  task automatic t_reset;
    rchk(`SCS_ADDR_RUN_CTL, `SCS_RUN_RESET, "run reset");
    @(posedge i_clk);
    #1;
    chk_byte(o_rdata, 8'h00, "read data idle");
    rchk(`SCS_ADDR_CLK_SEL, 8'h00, "select reset");
    rchk(`SCS_ADDR_SETTLE_SEL, 8'h07, "settle select reset");
    rchk(`SCS_ADDR_SETTLE_STAT, 8'h00, "settle status reset");
    chk_byte({hs_en, sub_en, mid_en, fast_en, gate, 3'h0}, 8'h58, "enables at reset");
    chk_byte({6'h00, clk_sel}, 8'h00, "main internal source");
    $display("TB: reset test done");
  endtask
  task automatic t_to_sub;
    do_switch(8'h40, SCS_SRC_SUB, 8'hc0, 8'hc0);
    $display("TB: move to sub clock done");
  endtask
  task automatic t_sub_to_mid;
    wr(`SCS_ADDR_RUN_CTL, 8'h82);
    chk_bit(mid_en, 1'b1, "mid oscillator start");
    // software settle wait, 1000 cycles is 4 us
    repeat (1000) @(posedge i_clk);
    do_switch(8'h03, SCS_SRC_MID, 8'hff, 8'h03);
    // Reserved bits written as one must still read back as zero
    wr(`SCS_ADDR_RUN_CTL, 8'hfe);
    rchk(`SCS_ADDR_RUN_CTL, 8'hc2, "run control mask");
    chk_bit(sub_en, 1'b0, "sub oscillator stop");
    $display("TB: sub to middle speed done");
  endtask
  task automatic t_sub_to_hs;
    int n;
    logic bad;
    wr(`SCS_ADDR_RUN_CTL, 8'h82);
    do_switch(8'h41, SCS_SRC_SUB, 8'hc0, 8'hc0);
    wr(`SCS_ADDR_SETTLE_SEL, 8'hfa);
    rchk(`SCS_ADDR_SETTLE_SEL, 8'h02, "settle select");
    wr(`SCS_ADDR_RUN_CTL, 8'h02);
    chk_bit(hs_en, 1'b1, "hs oscillator start");
    n = 0;
    bad = 1'b0;
    // Poll without judging; only the fill pattern and the end value count
    do begin
      rd(`SCS_ADDR_SETTLE_STAT);
      if (rv !== 8'h00 && rv !== 8'h80 && rv !== 8'hc0 && rv !== 8'he0) bad = 1'b1;
      n++;
    end while (rv !== 8'he0 && n < 2000);
    chk_bit(bad, 1'b0, "settle fill order");
    chk_byte(rv, 8'he0, "settle reached");
    chk_min(ticks, 1024, "ticks before ready");
    // Long enough for 1050 more ticks, past 2048 in all, so a counter that failed to halt would show bit 4
    repeat (2100) @(posedge i_clk);
    wr(`SCS_ADDR_SETTLE_STAT, 8'hff);
    rchk(`SCS_ADDR_SETTLE_STAT, 8'he0, "settle halts");
    do_switch(8'h10, SCS_SRC_HS, 8'hff, 8'h30);
    wr(`SCS_ADDR_RUN_CTL, 8'h42);
    chk_byte({hs_en, sub_en, 6'h00}, 8'h80, "sub stop on hs");
    $display("TB: sub to high speed done");
  endtask
  // External clock: settle select left alone, no settle wait, clock applied before start
  task automatic t_ext_clk;
    wr(`SCS_ADDR_RUN_CTL, 8'h02);
    do_switch(8'h50, SCS_SRC_SUB, 8'hf0, 8'hd0);
    wr(`SCS_ADDR_RUN_CTL, 8'h82);
    wr(`SCS_ADDR_RUN_CTL, 8'h02);
    rchk(`SCS_ADDR_SETTLE_STAT, 8'h00, "settle restarts");
    do_switch(8'h10, SCS_SRC_HS, 8'hff, 8'h30);
    wr(`SCS_ADDR_RUN_CTL, 8'h42);
    chk_bit(sub_en, 1'b0, "sub stop after external switch");
    $display("TB: external clock switch done");
  endtask
  task automatic results;
    $display("TB: %0d checks, %0d failures", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Reset, then the switching sequences in order
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 2'h0;
    i_wdata = 8'h00;
    failures = 0;
    check_count = 0;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_to_sub;
    t_sub_to_mid;
    t_sub_to_hs;
    t_ext_clk;
    results;
  end
  // Watchdog, well above the roughly 21 us the tests need
  initial begin
    #200us;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    results;
  end
endmodule // test_subclock_to_main_clock_switch
`default_nettype wire
